/* File: rtl/vdac_map.svh */
`ifndef VDAC_MAP_SVH
`define VDAC_MAP_SVH
// register addresses on the special function register bus
`define VDAC_ADDR_DATA_LOW 8'hFB
`define VDAC_ADDR_DATA_HIGH 8'hFC
`define VDAC_ADDR_CONTROL 8'hFD
// reset values
`define VDAC_CTRL_RESET 8'h00
`define VDAC_DATA_RESET 8'h00
`define VDAC_CODE_RESET 12'h000
// control bit positions
`define VDAC_BIT_ENABLE 0
`define VDAC_BIT_CLEAR_N 1
`define VDAC_BIT_RANGE 2
`define VDAC_BIT_BYTE_MODE 3
`define VDAC_BIT_PIN_SEL 4
// implemented control bits
`define VDAC_CTRL_MASK 8'h1F
// zero fill for the four low code bits in byte mode
`define VDAC_NIBBLE_ZERO 4'h0
// high byte bits that feed code bits 11 to 8
`define VDAC_NIB_MSB 3
`define VDAC_NIB_LSB 0
// unimplemented control bits and the value they keep
`define VDAC_UNUSED_MSB 7
`define VDAC_UNUSED_LSB 5
`define VDAC_UNUSED_ZERO 3'h0
// edges from a control write to the analog outputs
`define VDAC_CTRL_LAG 2
`endif

/* File: rtl/vdac_pkg.sv */
`default_nettype none
package vdac_pkg;
  // converter code word
  typedef logic [11:0] vdac_code_t;
  // register byte
  typedef logic [7:0] vdac_byte_t;
endpackage
`default_nettype wire

/* File: rtl/vdac_top.sv */
// Overview of operation
// - twelve-bit update happens on low byte write
// - code right-justified, high byte bits 3-0 hold bits 11-8
// - pin select bit routes output to common
// - byte mode: low byte gives eight MSBs
// - twelve-bit mode uses low byte plus nibble
// - range bit selects supply or reference range
// - clear bit low zeroes both data bytes
// - enable bit powers the converter up
// - control reads zero after reset, output floats
// - control bits seven to five ignored
`timescale 1ns/1ps
`default_nettype none
`include "vdac_map.svh"

module vdac_top (
  input wire logic mclk, // core clock, 250 MHz
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic [7:0] sfr_addr, // register address
  input wire logic [7:0] sfr_wdata, // write data
  input wire logic sfr_we, // write strobe, one cycle
  input wire logic sfr_re, // read strobe
  output logic [7:0] sfr_rdata, // registered read data
  output logic sfr_rvalid, // read data valid pulse
  output logic [11:0] converter_code, // code to the resistor string
  output logic converter_enable, // converter powered up
  output logic output_range_select, // 1 supply range, 0 reference
  output logic output_pin_select, // 1 common input pin, 0 own pin
  output logic dac_pin_drive_oe, // buffer drives dedicated pin
  output logic analog_common_drive_oe, // buffer drives common pin
  output logic code_update_pulse // code reloaded this cycle
);

  // control register, low five bits implemented
  vdac_pkg::vdac_byte_t converter_control_reg;
  // data byte registers
  vdac_pkg::vdac_byte_t converter_data_low_reg;
  vdac_pkg::vdac_byte_t converter_data_high_reg;
  // code latched into the converter
  vdac_pkg::vdac_code_t code_reg;
  vdac_pkg::vdac_code_t code_next;
  // decoded write strobes
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  // current control fields
  logic byte_mode_select;
  logic data_clear_n;
  // flip-flops behind the outputs
  vdac_pkg::vdac_byte_t sfr_rdata_reg; // last read value
  logic sfr_rvalid_reg; // read answer strobe
  logic code_update_pulse_reg; // code reload marker
  logic converter_enable_reg; // power-up request
  logic output_range_select_reg; // range choice
  logic output_pin_select_reg; // pin routing choice
  logic dac_pin_drive_oe_reg; // own pin buffer drive
  logic analog_common_drive_oe_reg; // common pin buffer drive

  // address decode
  assign wr_ctrl = sfr_we && (sfr_addr == `VDAC_ADDR_CONTROL);
  assign wr_low = sfr_we && (sfr_addr == `VDAC_ADDR_DATA_LOW);
  assign wr_high = sfr_we && (sfr_addr == `VDAC_ADDR_DATA_HIGH);
  assign byte_mode_select = converter_control_reg[`VDAC_BIT_BYTE_MODE];
  assign data_clear_n = converter_control_reg[`VDAC_BIT_CLEAR_N];

  // control register write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      converter_control_reg <= `VDAC_CTRL_RESET;
    end else if (wr_ctrl) begin
      converter_control_reg <= sfr_wdata & `VDAC_CTRL_MASK;
    end
  end

  // low data byte
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      converter_data_low_reg <= `VDAC_DATA_RESET;
    end else if (!data_clear_n) begin
      converter_data_low_reg <= `VDAC_DATA_RESET;
    end else if (wr_low) begin
      converter_data_low_reg <= sfr_wdata;
    end
  end

  // high data byte
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      converter_data_high_reg <= `VDAC_DATA_RESET;
    end else if (!data_clear_n) begin
      converter_data_high_reg <= `VDAC_DATA_RESET;
    end else if (wr_high) begin
      converter_data_high_reg <= sfr_wdata;
    end
  end

  // next code from the written low byte
  always_comb begin
    if (byte_mode_select) begin
      code_next = {sfr_wdata, `VDAC_NIBBLE_ZERO};
    end else begin
      code_next = {converter_data_high_reg[`VDAC_NIB_MSB:`VDAC_NIB_LSB],
        sfr_wdata};
    end
  end

  // converter code update
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // reset: zero code, no update marker
      code_reg <= `VDAC_CODE_RESET;
      code_update_pulse_reg <= 1'h0;
    end else if (!data_clear_n) begin
      code_reg <= `VDAC_CODE_RESET;
      code_update_pulse_reg <= 1'h0;
    end else begin
      // load on low byte write only
      code_update_pulse_reg <= wr_low;
      if (wr_low) begin
        // low byte write: take the new code
        code_reg <= code_next;
      end
    end
  end
  assign converter_code = code_reg;
  assign code_update_pulse = code_update_pulse_reg;

  // analog control outputs, registered
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // reset: powered down, buffer floating
      converter_enable_reg <= 1'h0;
      output_range_select_reg <= 1'h0;
      output_pin_select_reg <= 1'h0;
      dac_pin_drive_oe_reg <= 1'h0;
      analog_common_drive_oe_reg <= 1'h0;
    end else begin
      converter_enable_reg <= converter_control_reg[`VDAC_BIT_ENABLE];
      output_range_select_reg <= converter_control_reg[`VDAC_BIT_RANGE];
      output_pin_select_reg <= converter_control_reg[`VDAC_BIT_PIN_SEL];
      dac_pin_drive_oe_reg <= converter_control_reg[`VDAC_BIT_ENABLE] &&
        !converter_control_reg[`VDAC_BIT_PIN_SEL];
      analog_common_drive_oe_reg <=
        converter_control_reg[`VDAC_BIT_ENABLE] &&
        converter_control_reg[`VDAC_BIT_PIN_SEL];
    end
  end
  // analog outputs straight from their flip-flops
  assign converter_enable = converter_enable_reg;
  assign output_range_select = output_range_select_reg;
  assign output_pin_select = output_pin_select_reg;
  assign dac_pin_drive_oe = dac_pin_drive_oe_reg;
  assign analog_common_drive_oe = analog_common_drive_oe_reg;

  // register read mux
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // reset: no answer pending
      sfr_rdata_reg <= `VDAC_DATA_RESET;
      sfr_rvalid_reg <= 1'h0;
    end else begin
      // answer one cycle after the strobe
      sfr_rvalid_reg <= sfr_re;
      if (sfr_re) begin
        unique case (sfr_addr)
          `VDAC_ADDR_CONTROL: sfr_rdata_reg <= converter_control_reg;
          `VDAC_ADDR_DATA_LOW: sfr_rdata_reg <= converter_data_low_reg;
          `VDAC_ADDR_DATA_HIGH: sfr_rdata_reg <= converter_data_high_reg;
          // unmapped places read zero
          default: sfr_rdata_reg <= `VDAC_DATA_RESET;
        endcase
      end
    end
  end
  // read port straight from its flip-flops
  assign sfr_rdata = sfr_rdata_reg;
  assign sfr_rvalid = sfr_rvalid_reg;

  // checks
  property p_low_write_12;
    @(posedge mclk) disable iff (sys_rst)
      (wr_low && data_clear_n && !byte_mode_select) |=>
        converter_code ==
        {$past(converter_data_high_reg[`VDAC_NIB_MSB:`VDAC_NIB_LSB]),
        $past(sfr_wdata)};
  endproperty
  a_low_write_12: assert property (p_low_write_12)
    else $error("twelve-bit code not loaded on low write");

  property p_code_hold;
    @(posedge mclk) disable iff (sys_rst)
      (!wr_low && data_clear_n) |=> $stable(converter_code);
  endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("code changed without a low byte write");

  property p_pulse_source;
    @(posedge mclk) disable iff (sys_rst)
      code_update_pulse |-> $past(wr_low && data_clear_n);
  endproperty
  a_pulse_source: assert property (p_pulse_source)
    else $error("update marker without a low byte write");

  property p_high_no_update;
    @(posedge mclk) disable iff (sys_rst)
      (wr_high && !wr_low && data_clear_n) |=> $stable(converter_code);
  endproperty
  a_high_no_update: assert property (p_high_no_update)
    else $error("high byte write changed code");

  property p_byte_mode;
    @(posedge mclk) disable iff (sys_rst)
      (wr_low && data_clear_n && byte_mode_select) |=>
        converter_code == {$past(sfr_wdata), `VDAC_NIBBLE_ZERO};
  endproperty
  a_byte_mode: assert property (p_byte_mode)
    else $error("byte mode code wrong");

  property p_byte_pulse;
    @(posedge mclk) disable iff (sys_rst)
      (wr_low && data_clear_n && byte_mode_select) |=> code_update_pulse;
  endproperty
  a_byte_pulse: assert property (p_byte_pulse)
    else $error("byte mode low write did not update code");

  property p_clear;
    @(posedge mclk) disable iff (sys_rst)
      !data_clear_n |=> (converter_data_low_reg == `VDAC_DATA_RESET &&
        converter_data_high_reg == `VDAC_DATA_RESET &&
        converter_code == `VDAC_CODE_RESET);
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not zero data");

  property p_clear_no_pulse;
    @(posedge mclk) disable iff (sys_rst)
      !data_clear_n |=> !code_update_pulse;
  endproperty
  a_clear_no_pulse: assert property (p_clear_no_pulse)
    else $error("code updated while clear held");

  property p_pin_route;
    @(posedge mclk) disable iff (sys_rst)
      ##1 (analog_common_drive_oe ==
        ($past(converter_control_reg[`VDAC_BIT_PIN_SEL]) &&
        $past(converter_control_reg[`VDAC_BIT_ENABLE])));
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("common pin drive wrong");

  property p_dedicated_pin;
    @(posedge mclk) disable iff (sys_rst)
      (converter_enable && !output_pin_select) |->
        (dac_pin_drive_oe && !analog_common_drive_oe);
  endproperty
  a_dedicated_pin: assert property (p_dedicated_pin)
    else $error("dedicated pin drive wrong");

  property p_enable;
    @(posedge mclk) disable iff (sys_rst)
      wr_ctrl ##1 1'h1 |=> converter_enable ==
        $past(sfr_wdata[`VDAC_BIT_ENABLE], `VDAC_CTRL_LAG);
  endproperty
  a_enable: assert property (p_enable)
    else $error("enable not following control");

  property p_range;
    @(posedge mclk) disable iff (sys_rst)
      wr_ctrl ##1 1'h1 |=> output_range_select ==
        $past(sfr_wdata[`VDAC_BIT_RANGE], `VDAC_CTRL_LAG);
  endproperty
  a_range: assert property (p_range)
    else $error("range not following control");

  property p_upper_ignored;
    @(posedge mclk) disable iff (sys_rst)
      wr_ctrl |=>
        converter_control_reg[`VDAC_UNUSED_MSB:`VDAC_UNUSED_LSB] ==
        `VDAC_UNUSED_ZERO;
  endproperty
  a_upper_ignored: assert property (p_upper_ignored)
    else $error("unimplemented control bits stored");

  property p_ctrl_read_zero;
    @(posedge mclk) disable iff (sys_rst)
      (sfr_re && sfr_addr == `VDAC_ADDR_CONTROL) |=> (sfr_rvalid &&
        sfr_rdata[`VDAC_UNUSED_MSB:`VDAC_UNUSED_LSB] == `VDAC_UNUSED_ZERO);
  endproperty
  a_ctrl_read_zero: assert property (p_ctrl_read_zero)
    else $error("control read shows unimplemented bits");

  property p_float_off;
    @(posedge mclk) disable iff (sys_rst)
      !converter_enable |-> !dac_pin_drive_oe && !analog_common_drive_oe;
  endproperty
  a_float_off: assert property (p_float_off)
    else $error("buffer drives while disabled");

  c_update12: cover property (@(posedge mclk) disable iff (sys_rst)
    wr_high ##[1:4] (wr_low && !byte_mode_select));
  c_update8: cover property (@(posedge mclk) disable iff (sys_rst)
    wr_low && byte_mode_select);
  c_clear: cover property (@(posedge mclk) disable iff (sys_rst)
    !data_clear_n);
  c_common: cover property (@(posedge mclk) disable iff (sys_rst)
    analog_common_drive_oe);
  c_range: cover property (@(posedge mclk) disable iff (sys_rst)
    output_range_select && converter_enable);

endmodule // vdac_top
`default_nettype wire

/* File: testbench/vdac_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vdac_map.svh"
// compare two values, count it, report a mismatch
`define CHK(got, exp) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end

module vdac_top_tb_top;
  logic mclk = 1'h0; // core clock
  logic sys_rst = 1'h1; // reset, active high
  logic [7:0] sfr_addr = 8'h00; // register address
  logic [7:0] sfr_wdata = 8'h00; // write data
  logic sfr_we = 1'h0; // write strobe
  logic sfr_re = 1'h0; // read strobe
  logic [7:0] sfr_rdata; // read data
  logic sfr_rvalid; // read data valid
  logic [11:0] converter_code; // code to converter
  logic converter_enable; // converter powered
  logic output_range_select; // range select
  logic output_pin_select; // pin select
  logic dac_pin_drive_oe; // own pin drive
  logic analog_common_drive_oe; // common pin drive
  logic code_update_pulse; // code reloaded
  int bad_count = 0; // mismatches
  int n_tests = 0; // comparisons
  logic [31:0] seed = 32'h00000029; // random state
  vdac_pkg::vdac_byte_t rd_q[$]; // expected read data
  vdac_pkg::vdac_code_t cd_q[$]; // expected codes
  vdac_pkg::vdac_byte_t eb, hi, lo; // temporaries
  vdac_pkg::vdac_code_t ec; // expected code temp

  // clock, 4 ns period
  always #2 mclk = ~mclk;

  vdac_top i_vdac_top (.mclk(mclk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
    .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .converter_code(converter_code), .converter_enable(converter_enable),
    .output_range_select(output_range_select),
    .output_pin_select(output_pin_select),
    .dac_pin_drive_oe(dac_pin_drive_oe),
    .analog_common_drive_oe(analog_common_drive_oe),
    .code_update_pulse(code_update_pulse));

  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // verdict and end of run
  task automatic test_done();
    if (bad_count == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one write, then an idle cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'h1;
    @(negedge mclk);
    sfr_we = 1'h0;
    @(negedge mclk);
  endtask

  // control write, wait until analog outputs follow
  task automatic ctl(input logic [7:0] d);
    wr(`VDAC_ADDR_CONTROL, d);
    @(negedge mclk);
  endtask

  // high then low byte back to back
  task automatic pair(input logic [7:0] h, input logic [7:0] l);
    sfr_addr = `VDAC_ADDR_DATA_HIGH;
    sfr_wdata = h;
    sfr_we = 1'h1;
    @(negedge mclk);
    sfr_addr = `VDAC_ADDR_DATA_LOW;
    sfr_wdata = l;
    @(negedge mclk);
    sfr_we = 1'h0;
    @(negedge mclk);
  endtask

  // read, noting the expected byte
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    sfr_addr = a;
    sfr_re = 1'h1;
    @(negedge mclk);
    sfr_re = 1'h0;
    @(negedge mclk);
  endtask

  // monitor: match each result against the oldest note
  always @(posedge mclk) begin
    if (!sys_rst && sfr_rvalid) begin
      eb = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hXX;
      `CHK(sfr_rdata, eb)
    end
    if (!sys_rst && code_update_pulse) begin
      ec = (cd_q.size() > 0) ? cd_q.pop_front() : 12'hXXX;
      `CHK(converter_code, ec)
    end
  end

  // main sequence
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'h0;
    `CHK({converter_enable, dac_pin_drive_oe, analog_common_drive_oe}, 3'h0)
    rd(`VDAC_ADDR_CONTROL, 8'h00);
    ctl(8'hE3);
    rd(`VDAC_ADDR_CONTROL, 8'h03);
    `CHK({converter_enable, dac_pin_drive_oe, output_range_select}, 3'h6)
    // twelve-bit pairs, random
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      hi = seed[7:0];
      lo = seed[15:8];
      cd_q.push_back({hi[3:0], lo});
      pair(hi, lo);
    end
    // high byte alone leaves the code alone
    wr(`VDAC_ADDR_DATA_HIGH, ~hi);
    `CHK(converter_code, {hi[3:0], lo})
    rd(`VDAC_ADDR_DATA_HIGH, ~hi);
    // byte mode
    ctl(8'h0B);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      lo = seed[7:0];
      cd_q.push_back({lo, `VDAC_NIBBLE_ZERO});
      wr(`VDAC_ADDR_DATA_LOW, lo);
    end
    // range and pin routing
    ctl(8'h17);
    `CHK({output_pin_select, output_range_select}, 2'h3)
    `CHK({analog_common_drive_oe, dac_pin_drive_oe}, 2'h2)
    ctl(8'h12);
    `CHK({converter_enable, analog_common_drive_oe}, 2'h0)
    // clear held low wipes data and blocks writes
    ctl(8'h01);
    `CHK(converter_code, 12'h000)
    rd(`VDAC_ADDR_DATA_HIGH, 8'h00);
    wr(`VDAC_ADDR_DATA_LOW, 8'h55);
    rd(`VDAC_ADDR_DATA_LOW, 8'h00);
    // unmapped place
    wr(8'h10, 8'hAA);
    rd(8'h10, 8'h00);
    // reset in mid-run while the converter is powered
    sys_rst = 1'h1;
    repeat (4) @(negedge mclk);
    sys_rst = 1'h0;
    `CHK({converter_enable, dac_pin_drive_oe}, 2'h0)
    rd(`VDAC_ADDR_CONTROL, 8'h00);
    repeat (2) @(negedge mclk);
    `CHK(rd_q.size() + cd_q.size(), 0)
    test_done();
  end

  // watchdog
  initial begin
    #20000;
    bad_count++;
    test_done();
  end
endmodule // vdac_top_tb_top
`default_nettype wire
